// ---- src/tsp_defs.vh ----
// Constants for the single pulse and capture timer block
`ifndef TSP_DEFS_VH
`define TSP_DEFS_VH

// ----------------------------------------
// AXI4-Lite register byte offsets
// ----------------------------------------
`define TSP_OFF_CTRL 4'h0
`define TSP_OFF_CFG 4'h4
`define TSP_OFF_CMPA 4'h8
`define TSP_OFF_CMPP 4'hc
`define TSP_ADDR_W 4

// ----------------------------------------
// Register select bits and byte lanes
// ----------------------------------------
`define TSP_SEL_CTRL 0
`define TSP_SEL_CFG 1
`define TSP_SEL_CMPA 2
`define TSP_SEL_CMPP 3
`define TSP_LANE_LO 0
`define TSP_LANE_HI 1
`define TSP_BYTE_MSB 7
`define TSP_HI_LSB 8
`define TSP_FIELD_W 2

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TSP_CTRL_RUN 0
`define TSP_CTRL_MAF 1
`define TSP_CTRL_MPF 2
`define TSP_CTRL_CNT_LSB 16

// ----------------------------------------
// Config register fields
// ----------------------------------------
`define TSP_CFG_SWAP 0
`define TSP_CFG_CLR 1
`define TSP_CFG_INV 2
`define TSP_CFG_INIT 3
`define TSP_CFG_PIN_LSB 4
`define TSP_CFG_MODE_LSB 6

// ----------------------------------------
// Encodings
// ----------------------------------------
`define TSP_MODE_CAPTURE 2'h1
`define TSP_MODE_PULSE 2'h2
`define TSP_PIN_PULSE 2'h3
`define TSP_EDGE_RISE 2'h0
`define TSP_EDGE_FALL 2'h1
`define TSP_EDGE_BOTH 2'h2
`define TSP_EDGE_OFF 2'h3

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define TSP_RESP_OKAY 2'h0
`define TSP_RESP_SLVERR 2'h2

`endif

// ---- src/tsp_timer.v ----
// Single pulse output and capture input timer with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
// ----------------------------------------
// Overview of operation
// ----------------------------------------
module tsp_timer #(
	parameter CNT_W = 10
) (
	input wire ref_clk,
	input wire arst_n,
	input wire timer_tick,
	input wire ext_clock_pin,
	input wire capture_input_pin,
	output reg pulse_out,
	output reg timer_irq,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
`include "tsp_defs.vh"

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [CNT_W-1:0] count_reg;
	reg [CNT_W-1:0] compare_a_value_reg;
	reg [CNT_W-1:0] compare_p_value_reg;
	reg counter_run_reg;
	reg run_prev_reg;
	reg [1:0] mode_select_reg;
	reg [1:0] pin_function_reg;
	reg output_initial_level_reg;
	reg output_invert_reg;
	reg clear_source_select_reg;
	reg duty_period_swap_reg;
	reg match_a_flag_reg;
	reg match_p_flag_reg;
	reg ext_prev_reg;
	reg cap_prev_reg;
	reg cap_pend_reg;
	reg maf_pend_reg;
	reg [3:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg aw_have_reg;
	reg w_have_reg;

	wire pulse_mode = (mode_select_reg == `TSP_MODE_PULSE) && (pin_function_reg == `TSP_PIN_PULSE);
	wire capture_mode = (mode_select_reg == `TSP_MODE_CAPTURE);
	wire run_rise = counter_run_reg && !run_prev_reg;
	wire ext_edge = ext_clock_pin && !ext_prev_reg;
	wire cap_rise = capture_input_pin && !cap_prev_reg;
	wire cap_fall = !capture_input_pin && cap_prev_reg;
	reg cap_edge;

	always @*
	begin
		case (pin_function_reg)
			`TSP_EDGE_RISE: cap_edge = cap_rise;
			`TSP_EDGE_FALL: cap_edge = cap_fall;
			`TSP_EDGE_BOTH: cap_edge = cap_rise | cap_fall;
			default: cap_edge = 1'b0;
		endcase
	end

	wire counting = counter_run_reg && run_prev_reg && timer_tick;
	// Match A only counts when the counter actually sits on it while running
	wire match_a = pulse_mode && counting && (count_reg == compare_a_value_reg);
	// P zero never matches, so the counter rolls over at full scale
	wire match_p = capture_mode && counting && (compare_p_value_reg != {CNT_W{1'b0}})
		&& (count_reg == compare_p_value_reg);

	// ----------------------------------------
	// Register bus write decode
	// ----------------------------------------
	// Unmapped offsets give an all-zero select and a slave error
	function [3:0] reg_sel;
		input [3:0] addr;
		begin
			reg_sel = 4'h0;
			if (addr == `TSP_OFF_CTRL)
				reg_sel[`TSP_SEL_CTRL] = 1'b1;
			else if (addr == `TSP_OFF_CFG)
				reg_sel[`TSP_SEL_CFG] = 1'b1;
			else if (addr == `TSP_OFF_CMPA)
				reg_sel[`TSP_SEL_CMPA] = 1'b1;
			else if (addr == `TSP_OFF_CMPP)
				reg_sel[`TSP_SEL_CMPP] = 1'b1;
		end
	endfunction

	wire [3:0] wr_sel = reg_sel(awaddr_reg);
	wire [3:0] rd_sel = reg_sel(s_axi_araddr);
	wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire wr_ctrl = do_write && wr_sel[`TSP_SEL_CTRL] && wstrb_reg[`TSP_LANE_LO];
	wire wr_cfg = do_write && wr_sel[`TSP_SEL_CFG] && wstrb_reg[`TSP_LANE_LO];
	wire wr_cmpa_lo = do_write && wr_sel[`TSP_SEL_CMPA] && wstrb_reg[`TSP_LANE_LO];
	wire wr_cmpa_hi = do_write && wr_sel[`TSP_SEL_CMPA] && wstrb_reg[`TSP_LANE_HI];
	wire wr_cmpp_lo = do_write && wr_sel[`TSP_SEL_CMPP] && wstrb_reg[`TSP_LANE_LO];
	wire wr_cmpp_hi = do_write && wr_sel[`TSP_SEL_CMPP] && wstrb_reg[`TSP_LANE_HI];
	wire wr_known = |wr_sel;

	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TSP_RESP_OKAY;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end
		else
		begin
			s_axi_awready <= !aw_have_reg && !s_axi_awready;
			s_axi_wready <= !w_have_reg && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `TSP_RESP_OKAY : `TSP_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Register bus read
	// ----------------------------------------
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `TSP_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `TSP_RESP_OKAY;
				s_axi_rdata <= 32'h0;
				if (rd_sel[`TSP_SEL_CTRL])
				begin
					s_axi_rdata[`TSP_CTRL_RUN] <= counter_run_reg;
					s_axi_rdata[`TSP_CTRL_MAF] <= match_a_flag_reg;
					s_axi_rdata[`TSP_CTRL_MPF] <= match_p_flag_reg;
					s_axi_rdata[`TSP_CTRL_CNT_LSB +: CNT_W] <= count_reg;
				end
				else if (rd_sel[`TSP_SEL_CFG])
				begin
					s_axi_rdata[`TSP_CFG_SWAP] <= duty_period_swap_reg;
					s_axi_rdata[`TSP_CFG_CLR] <= clear_source_select_reg;
					s_axi_rdata[`TSP_CFG_INV] <= output_invert_reg;
					s_axi_rdata[`TSP_CFG_INIT] <= output_initial_level_reg;
					s_axi_rdata[`TSP_CFG_PIN_LSB +: `TSP_FIELD_W] <= pin_function_reg;
					s_axi_rdata[`TSP_CFG_MODE_LSB +: `TSP_FIELD_W] <= mode_select_reg;
				end
				else if (rd_sel[`TSP_SEL_CMPA])
					s_axi_rdata[CNT_W-1:0] <= compare_a_value_reg;
				else if (rd_sel[`TSP_SEL_CMPP])
					s_axi_rdata[CNT_W-1:0] <= compare_p_value_reg;
				else
					s_axi_rresp <= `TSP_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Timer core
	// ----------------------------------------
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count_reg <= {CNT_W{1'b0}};
			compare_a_value_reg <= {CNT_W{1'b0}};
			counter_run_reg <= 1'b0;
			match_a_flag_reg <= 1'b0;
			match_p_flag_reg <= 1'b0;
			cap_pend_reg <= 1'b0;
			maf_pend_reg <= 1'b0;
			timer_irq <= 1'b0;
		end
		else
		begin
			timer_irq <= 1'b0;

			if (wr_cmpa_lo)
				compare_a_value_reg[`TSP_BYTE_MSB:0] <= wdata_reg[`TSP_BYTE_MSB:0];
			if (wr_cmpa_hi)
				compare_a_value_reg[CNT_W-1:`TSP_HI_LSB] <= wdata_reg[CNT_W-1:`TSP_HI_LSB];

			// Flags: write one to clear, hardware set wins
			if (wr_ctrl)
			begin
				counter_run_reg <= wdata_reg[`TSP_CTRL_RUN];
				if (wdata_reg[`TSP_CTRL_MAF])
					match_a_flag_reg <= 1'b0;
				if (wdata_reg[`TSP_CTRL_MPF])
					match_p_flag_reg <= 1'b0;
			end
			if (pulse_mode && ext_edge)
				counter_run_reg <= 1'b1;
			if (match_a)
			begin
				counter_run_reg <= 1'b0;
				match_a_flag_reg <= 1'b1;
				timer_irq <= 1'b1;
			end

			// Counter
			if (run_rise)
				count_reg <= {CNT_W{1'b0}};
			else if (match_p)
				count_reg <= {CNT_W{1'b0}};
			else if (counting && !match_a)
				count_reg <= count_reg + 1'b1;

			if (match_p)
			begin
				match_p_flag_reg <= 1'b1;
				timer_irq <= 1'b1;
			end

			// Capture: edge latched on the next timer tick, flag one cycle after
			if (capture_mode && counter_run_reg && cap_edge)
				cap_pend_reg <= 1'b1;
			if (cap_pend_reg && timer_tick)
			begin
				cap_pend_reg <= 1'b0;
				compare_a_value_reg <= count_reg;
				maf_pend_reg <= 1'b1;
			end
			if (maf_pend_reg)
			begin
				maf_pend_reg <= 1'b0;
				match_a_flag_reg <= 1'b1;
				timer_irq <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Configuration and compare P
	// ----------------------------------------
	// Compare A stays with the core, since a capture also loads it
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			compare_p_value_reg <= {CNT_W{1'b0}};
			mode_select_reg <= 2'h0;
			pin_function_reg <= 2'h0;
			output_initial_level_reg <= 1'b0;
			output_invert_reg <= 1'b0;
			clear_source_select_reg <= 1'b0;
			duty_period_swap_reg <= 1'b0;
		end
		else
		begin
			if (wr_cfg)
			begin
				duty_period_swap_reg <= wdata_reg[`TSP_CFG_SWAP];
				clear_source_select_reg <= wdata_reg[`TSP_CFG_CLR];
				output_invert_reg <= wdata_reg[`TSP_CFG_INV];
				output_initial_level_reg <= wdata_reg[`TSP_CFG_INIT];
				pin_function_reg <= wdata_reg[`TSP_CFG_PIN_LSB +: `TSP_FIELD_W];
				mode_select_reg <= wdata_reg[`TSP_CFG_MODE_LSB +: `TSP_FIELD_W];
			end
			if (wr_cmpp_lo)
				compare_p_value_reg[`TSP_BYTE_MSB:0] <= wdata_reg[`TSP_BYTE_MSB:0];
			if (wr_cmpp_hi)
				compare_p_value_reg[CNT_W-1:`TSP_HI_LSB] <= wdata_reg[CNT_W-1:`TSP_HI_LSB];
		end
	end

	// ----------------------------------------
	// Edge history of run bit and pins
	// ----------------------------------------
	// Reset values match the idle pin level, so no false edge follows reset
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			run_prev_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			cap_prev_reg <= 1'b0;
		end
		else
		begin
			run_prev_reg <= counter_run_reg;
			ext_prev_reg <= ext_clock_pin;
			cap_prev_reg <= capture_input_pin;
		end
	end

	// ----------------------------------------
	// Output pin
	// ----------------------------------------
	// Level follows run, so a software clear ends the pulse as well
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			pulse_out <= 1'b0;
		else if (pulse_mode)
			pulse_out <= (counter_run_reg ? output_initial_level_reg : !output_initial_level_reg)
				^ output_invert_reg;
		else
			pulse_out <= 1'b0;
	end

endmodule // tsp_timer

// ---- test/tsp_pins_model.sv ----
// Far-side model: timer clock enable, trigger pin and capture pin
`timescale 1ns/1ns
module tsp_pins_model #(
	parameter TICK_DIV = 3
) (
	input wire ref_clk,
	input wire arst_n,
	output reg timer_tick = 1'b0,
	output reg ext_clock_pin = 1'b0,
	output reg capture_input_pin = 1'b0
);
	integer div_reg;
	always @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
		begin
			div_reg <= 0;
			timer_tick <= 1'b0;
		end
		else
		begin
			div_reg <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
			timer_tick <= div_reg == TICK_DIV - 1;
		end
	task automatic ext_pulse(input integer n);
		@(posedge ref_clk);
		ext_clock_pin <= 1'b1;
		repeat (n) @(posedge ref_clk);
		ext_clock_pin <= 1'b0;
	endtask
	// Width of two ticks or more, so no edge may be filtered
	task automatic cap_pulse(input integer n);
		@(posedge ref_clk);
		capture_input_pin <= 1'b1;
		repeat (n) @(posedge ref_clk);
		capture_input_pin <= 1'b0;
	endtask
endmodule // tsp_pins_model

// ---- test/tsp_timer_sva.sv ----
// Port-level checks for the single pulse and capture timer
`timescale 1ns/1ns
`include "tsp_defs.vh"
module tsp_timer_sva (
	input wire ref_clk,
	input wire arst_n,
	input wire pulse_out,
	input wire timer_irq,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	reg [7:0] cfg_reg;
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire cap_mode = cfg_reg[7:6] == `TSP_MODE_CAPTURE;
	wire pls_mode = cfg_reg[7:6] == `TSP_MODE_PULSE && cfg_reg[5:4] == `TSP_PIN_PULSE;
	// Snooped config; only same-cycle address and data are tracked
	always @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			cfg_reg <= 8'h00;
		else if (aw_hs && w_hs && s_axi_awaddr == `TSP_OFF_CFG && s_axi_wstrb[0])
			cfg_reg <= s_axi_wdata[7:0];
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken early");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken early");
	a_bresp_delay: assert property ($rose(s_axi_bvalid) |-> $past(aw_hs || w_hs, 2))
		else $error("write answer timing");
	a_capture_quiet: assert property (cap_mode [*5] |-> !pulse_out)
		else $error("output in capture mode");
	a_pulse_ends: assert property (pls_mode && timer_irq |-> ##[0:2] pulse_out == (cfg_reg[3] ~^ cfg_reg[2]))
		else $error("pulse not ended");
	c_pulse_irq: cover property (pls_mode && timer_irq);
	c_capture_irq: cover property (cap_mode && timer_irq);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule // tsp_timer_sva
bind tsp_timer tsp_timer_sva i_sva (.*);

// ---- test/tsp_timer_tb.sv ----
// Self-checking bench for the single pulse and capture timer
`timescale 1ns/1ns
`include "tsp_defs.vh"
module tsp_timer_tb;
	localparam DIV = 3;
	logic ref_clk = 0;
	logic arst_n = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic timer_tick, ext_clock_pin, capture_input_pin, pulse_out, timer_irq;
	logic [33:0] rq[$];
	logic [1:0] wq[$];
	int n_errors = 0, checks_done = 0, n_irq = 0, n0, i;
	int exp_irq[4] = '{1, 1, 2, 0};
	tsp_timer i_dut (.*);
	tsp_pins_model #(.TICK_DIV(DIV)) i_pins (.*);
	// ----------
	// Bus, wait and check tasks
	// ----------
	task automatic chk(string what, logic [33:0] e, logic [33:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Answer readies stand high from the request until the answer is taken
	task automatic xfer(bit w, logic [3:0] a, logic [31:0] v, logic [33:0] e);
		int k;
		if (w)
			wq.push_back(e[33:32]);
		else
			rq.push_back(e);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		s_axi_bready <= w;
		s_axi_rready <= !w;
		for (k = 0; k < 40; k++)
		begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			if (s_axi_arready)
				s_axi_arvalid <= 0;
			if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready)
				break;
		end
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		chk("bus wait", 0, k == 40);
		if (k == 40)
			finish_test;
	endtask
	task automatic wait_po(logic v);
		int k;
		for (k = 0; k < 300 && pulse_out !== v; k++)
			@(posedge ref_clk);
		chk("pulse_out", v, pulse_out);
		if (k == 300)
			finish_test;
	endtask
	task automatic wait_irq(output int k);
		n0 = n_irq;
		for (k = 0; k < 300 && n_irq == n0; k++)
			@(posedge ref_clk);
		chk("irq", 1, n_irq != n0);
		if (k == 300)
			finish_test;
	endtask
	always @(posedge ref_clk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", wq.pop_front(), s_axi_bresp);
		if (s_axi_rvalid && s_axi_rready)
			chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (timer_irq === 1'b1)
			n_irq <= n_irq + 1;
	end
	initial
		forever #5 ref_clk = ~ref_clk;
	// ----------
	// Scenarios
	// ----------
	initial
	begin
		d = $urandom(32'h120aad8f);
		repeat (8) @(posedge ref_clk);
		arst_n <= 1;
		for (i = 0; i < 16; i += 4)
			xfer(0, i[3:0], 0, 0);
		xfer(0, 4'h6, 0, {`TSP_RESP_SLVERR, 32'h0});
		d = $urandom;
		xfer(1, `TSP_OFF_CMPA, d, 0);
		xfer(0, `TSP_OFF_CMPA, 0, d & 32'h3ff);
		xfer(1, `TSP_OFF_CMPA, 5, 0);
		xfer(1, `TSP_OFF_CMPP, 2, 0);
		xfer(1, `TSP_OFF_CFG, 32'hbb, 0);
		i_pins.ext_pulse(4);
		wait_po(1);
		wait_irq(i);
		wait_po(0);
		xfer(0, `TSP_OFF_CTRL, 0, 34'h0_0005_0002);
		xfer(1, `TSP_OFF_CTRL, 2, 0);
		xfer(1, `TSP_OFF_CMPA, 32'h3ff, 0);
		xfer(1, `TSP_OFF_CFG, 32'hbc, 0);
		wait_po(1);
		xfer(1, `TSP_OFF_CTRL, 1, 0);
		wait_po(0);
		xfer(1, `TSP_OFF_CTRL, 0, 0);
		wait_po(1);
		xfer(1, `TSP_OFF_CMPP, 0, 0);
		for (i = 0; i < 4; i++)
		begin
			xfer(1, `TSP_OFF_CFG, 32'h4f | i << 4, 0);
			xfer(1, `TSP_OFF_CTRL, 1, 0);
			d = n_irq;
			i_pins.cap_pulse(2 * DIV + $urandom % 9);
			repeat (12) @(posedge ref_clk);
			chk("capture irqs", exp_irq[i], n_irq - d);
			chk("pulse_out", 0, pulse_out);
			xfer(1, `TSP_OFF_CTRL, 6, 0);
		end
		xfer(1, `TSP_OFF_CMPP, 4, 0);
		xfer(1, `TSP_OFF_CTRL, 1, 0);
		wait_irq(i);
		wait_irq(i);
		chk("match period", 5 * DIV, i);
		finish_test;
	end
endmodule // tsp_timer_tb
